// [pkg/rpac_pkg.sv]
// Constants shared by the real-time clock block: register offsets,
// control field positions, widths, reset values and divider figures.
// Assumes a 16-bit internal peripheral bus with byte addresses.
package rpac_pkg;

  // Bus widths.
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;

  // Register offsets on the internal peripheral bus.
  localparam logic [15:0] OFS_CTRL       = 16'hec00;
  localparam logic [15:0] OFS_PRESC_LO   = 16'hec06;
  localparam logic [15:0] OFS_PRESC_HI   = 16'hec08;
  localparam logic [15:0] OFS_DIV_LO     = 16'hec0a;
  localparam logic [15:0] OFS_DIV_HI     = 16'hec0c;
  localparam logic [15:0] OFS_TIME_LO    = 16'hec0e;
  localparam logic [15:0] OFS_TIME_HI    = 16'hec10;
  localparam logic [15:0] OFS_ALARM_LO   = 16'hec12;
  localparam logic [15:0] OFS_ALARM_HI   = 16'hec14;

  // Control register fields, all active high.
  localparam int CTRL_TICK_FLAG  = 0;
  localparam int CTRL_TICK_EN    = 1;
  localparam int CTRL_ALARM_FLAG = 2;
  localparam int CTRL_ALARM_EN   = 3;
  localparam int CTRL_OFF        = 4;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Interrupt sources: index 0 is the tick, index 1 is the alarm.
  localparam int NUM_SRC = 2;
  localparam int SRC_FLAG_POS [NUM_SRC] = '{CTRL_TICK_FLAG, CTRL_ALARM_FLAG};
  localparam int SRC_EN_POS   [NUM_SRC] = '{CTRL_TICK_EN, CTRL_ALARM_EN};

  // Divider chain: fixed predivider, split programmable divider, time counter.
  localparam int PRE_DIV    = 64;
  localparam int PRE_W      = 6;
  localparam int DIV_HI_W   = 4;
  localparam int DIV_LO_W   = 16;
  localparam int DIV_W      = DIV_HI_W + DIV_LO_W;
  localparam int TIME_W     = 32;
  localparam int CHAIN_W    = PRE_W + DIV_W + TIME_W;
  localparam logic [PRE_W-1:0] PRE_LAST = 6'(PRE_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ONE  = 20'h00001;

  // Power-on values of the timing registers.
  localparam logic [DIV_W-1:0]  PRESC_RESET = 20'h00000;
  localparam logic [TIME_W-1:0] TIME_RESET  = 32'h0000_0000;

endpackage : rpac_pkg

// [rtl/rpac_divider.sv]
// Fixed divide-by-64 predivider followed by the 20-bit reloadable divider.
// Assumes the caller gates it with run and pulses load after a prescale change.
`timescale 1ns/1ps
module rpac_divider (
  // Clock and power-on reset.
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  // Control from the register file.
  input  wire logic                       run,
  input  wire logic                       load,
  input  wire logic [rpac_pkg::DIV_W-1:0] prescale,
  // Divider state and reference tick.
  output logic      [rpac_pkg::DIV_W-1:0] divCount,
  output logic                            tick
);
  import rpac_pkg::*;

  logic [PRE_W-1:0] preCount_ff;
  logic [DIV_W-1:0] divCount_ff;
  logic             tick_ff;
  logic             preStrobe;
  logic             divLast;

  // One enable pulse every 64 core clocks while running.
  assign preStrobe = run && (preCount_ff == PRE_LAST);
  // A count of zero also ends the period, so a zero prescale cannot hang.
  assign divLast   = (divCount_ff <= DIV_ONE);

  // Predivider; restarted on a prescale change so the new period is exact.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      preCount_ff <= '0;
    end else if (load) begin
      preCount_ff <= '0;
    end else if (run) begin
      preCount_ff <= preCount_ff + 6'h01;
    end
  end

  // Divider counts down the prescale value and reloads once per period.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divCount_ff <= PRESC_RESET;
    end else if (load) begin
      divCount_ff <= prescale;
    end else if (preStrobe) begin
      if (divLast) begin
        divCount_ff <= prescale;
      end else begin
        divCount_ff <= divCount_ff - DIV_ONE;
      end
    end
  end

  // Reference tick: period is 64 times the prescale value in core clocks, and 64 clocks for a prescale of zero.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= preStrobe && divLast && !load;
    end
  end

  assign divCount = divCount_ff;
  assign tick     = tick_ff;

endmodule : rpac_divider

// [rtl/rpac_rtc.sv]
// Real-time clock: register file on the internal peripheral bus, 32-bit
// time counter, alarm compare, two interrupt request lines and wake logic.
// Assumes clk is the crystal-derived core clock and rst_b is a power-on
// reset only; the chip's system reset is not wired to this block.
`timescale 1ns/1ps
module rpac_rtc (
  // Clock and power-on reset.
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  // Internal peripheral bus slave, word access.
  input  wire logic                        busSel,
  input  wire logic                        busWr,
  input  wire logic                        busRd,
  input  wire logic [rpac_pkg::ADDR_W-1:0] busAddr,
  input  wire logic [rpac_pkg::DATA_W-1:0] busWrData,
  output logic      [rpac_pkg::DATA_W-1:0] busRdData,
  // Chip power state and wake permission from the system configuration.
  input  wire logic                        powerDown,
  input  wire logic                        powerdownWakeConfig,
  // Port 2 request lines, wake request and oscillator control.
  output logic                             tickIrqRequest,
  output logic                             alarmIrqRequest,
  output logic                             wakeReq,
  output logic                             oscOff
);
  import rpac_pkg::*;

  // Control bits.
  logic                 switchOffBit_ff;
  logic [NUM_SRC-1:0]   irqEnable_ff;
  logic [NUM_SRC-1:0]   irqFlag_ff;
  logic [NUM_SRC-1:0]   irqLine_ff;

  // Timing and alarm registers.
  logic [DIV_LO_W-1:0]  prescaleLower_ff;
  logic [DIV_HI_W-1:0]  prescaleUpper_ff;
  logic [TIME_W-1:0]    timeCount_ff;
  logic [TIME_W-1:0]    alarmValue_ff;
  logic                 prescaleLoad_ff;

  // Output flops.
  logic [DATA_W-1:0]    rdData_ff;
  logic                 wakeReq_ff;
  logic                 oscOff_ff;

  // Decode and datapath nets.
  logic                 wrHit;
  logic                 rdHit;
  logic                 wrCtrl;
  logic                 wrPrescLo;
  logic                 wrPrescHi;
  logic                 wrTimeLo;
  logic                 wrTimeHi;
  logic                 wrAlarmLo;
  logic                 wrAlarmHi;
  logic                 running;
  logic [DIV_W-1:0]     prescaleValue;
  logic [DIV_W-1:0]     divCount;
  logic                 divTick;
  logic                 refTick;
  logic [TIME_W-1:0]    nxt_timeCount;
  logic                 alarmMatch;
  logic [NUM_SRC-1:0]   srcEvent;
  logic [DATA_W-1:0]    ctrlView;
  logic [DATA_W-1:0]    rdMux;

  // Bus decode: one word per register at its byte offset.
  assign wrHit     = busSel && busWr;
  assign rdHit     = busSel && busRd;
  assign wrCtrl    = wrHit && (busAddr == OFS_CTRL);
  assign wrAlarmLo = wrHit && (busAddr == OFS_ALARM_LO);
  assign wrAlarmHi = wrHit && (busAddr == OFS_ALARM_HI);

  // Timing registers only accept writes while switch-off is set; other
  // writes are dropped silently so a running clock never jumps.
  assign wrPrescLo = wrHit && switchOffBit_ff && (busAddr == OFS_PRESC_LO);
  assign wrPrescHi = wrHit && switchOffBit_ff && (busAddr == OFS_PRESC_HI);
  assign wrTimeLo  = wrHit && switchOffBit_ff && (busAddr == OFS_TIME_LO);
  assign wrTimeHi  = wrHit && switchOffBit_ff && (busAddr == OFS_TIME_HI);

  // Counting runs only while switch-off is clear, power-down or not.
  assign running       = !switchOffBit_ff;
  assign prescaleValue = {prescaleUpper_ff, prescaleLower_ff};

  // Switch-off bit and the two enables; reset clears all control bits.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      switchOffBit_ff <= CTRL_RESET[CTRL_OFF];
      irqEnable_ff    <= '0;
    end else if (wrCtrl) begin
      switchOffBit_ff <= busWrData[CTRL_OFF];
      irqEnable_ff[0] <= busWrData[CTRL_TICK_EN];
      irqEnable_ff[1] <= busWrData[CTRL_ALARM_EN];
    end
  end

  // Prescale halves. The reset here is power-on only, so a system
  // reset that leaves rst_b high keeps the programmed rate.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prescaleLower_ff <= PRESC_RESET[DIV_LO_W-1:0];
      prescaleUpper_ff <= PRESC_RESET[DIV_W-1:DIV_LO_W];
    end else begin
      if (wrPrescLo) begin
        prescaleLower_ff <= busWrData;
      end
      if (wrPrescHi) begin
        prescaleUpper_ff <= busWrData[DIV_HI_W-1:0];
      end
    end
  end

  // A prescale write reloads the divider on the following edge, once the
  // new value sits in the register.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prescaleLoad_ff <= 1'b0;
    end else begin
      prescaleLoad_ff <= wrPrescLo || wrPrescHi;
    end
  end

  // Predivider and 20-bit divider; together with the time counter they
  // form the 58-bit chain, the low six bits internal to the divider.
  rpac_divider uDivider (
    .clk      (clk),
    .rst_b    (rst_b),
    .run      (running),
    .load     (prescaleLoad_ff),
    .prescale (prescaleValue),
    .divCount (divCount),
    .tick     (divTick)
  );

  // A tick that matures as the clock is switched off is discarded.
  assign refTick       = divTick && running;
  // The add is kept at 32 bits, so the maximum value rolls over to zero.
  assign nxt_timeCount = timeCount_ff + 32'h0000_0001;
  assign alarmMatch    = (nxt_timeCount == alarmValue_ff);

  // Time counter: loaded by software when stopped, else counts ticks.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timeCount_ff <= TIME_RESET;
    end else if (wrTimeLo || wrTimeHi) begin
      if (wrTimeLo) begin
        timeCount_ff[DIV_LO_W-1:0] <= busWrData;
      end
      if (wrTimeHi) begin
        timeCount_ff[TIME_W-1:DIV_LO_W] <= busWrData;
      end
    end else if (refTick) begin
      timeCount_ff <= nxt_timeCount;
    end
  end

  // Alarm value is never write-protected, so it can be moved while running.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      alarmValue_ff <= TIME_RESET;
    end else begin
      if (wrAlarmLo) begin
        alarmValue_ff[DIV_LO_W-1:0] <= busWrData;
      end
      if (wrAlarmHi) begin
        alarmValue_ff[TIME_W-1:DIV_LO_W] <= busWrData;
      end
    end
  end

  // Source events: every tick, and the tick that makes the count equal
  // the alarm. Matching on the tick keeps one event per match.
  assign srcEvent[0] = refTick;
  assign srcEvent[1] = refTick && alarmMatch;

  // Per source: sticky flag and registered request line.
  generate
    for (genvar s = 0; s < NUM_SRC; s++) begin : gSrc
      // An enabled event sets the flag and beats a software write in the
      // same cycle; a write of zero otherwise clears it until the next event.
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          irqFlag_ff[s] <= 1'b0;
        end else if (srcEvent[s] && irqEnable_ff[s]) begin
          irqFlag_ff[s] <= 1'b1;
        end else if (wrCtrl) begin
          irqFlag_ff[s] <= busWrData[SRC_FLAG_POS[s]];
        end
      end

      // The line rises one clock after the flag, giving the port the rising edge it
      // expects; a disabled source holds its line low.
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          irqLine_ff[s] <= 1'b0;
        end else begin
          irqLine_ff[s] <= irqFlag_ff[s] && irqEnable_ff[s];
        end
      end
    end
  endgenerate

  // Wake request: a pending enabled request in power-down, when the
  // system configuration allows the clock to wake the chip. A delayed
  // wake-up is an alarm set the wanted number of ticks ahead.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wakeReq_ff <= 1'b0;
    end else begin
      wakeReq_ff <= powerDown && powerdownWakeConfig && (|irqLine_ff);
    end
  end

  // The oscillator stops in power-down only when switched off.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oscOff_ff <= 1'b0;
    end else begin
      oscOff_ff <= powerDown && switchOffBit_ff;
    end
  end

  // Control as read back; unused upper bits read zero.
  always_comb begin
    ctrlView                  = '0;
    ctrlView[CTRL_TICK_FLAG]  = irqFlag_ff[0];
    ctrlView[CTRL_TICK_EN]    = irqEnable_ff[0];
    ctrlView[CTRL_ALARM_FLAG] = irqFlag_ff[1];
    ctrlView[CTRL_ALARM_EN]   = irqEnable_ff[1];
    ctrlView[CTRL_OFF]        = switchOffBit_ff;
  end

  // Read multiplexer; unmapped addresses read zero.
  always_comb begin
    rdMux = '0;
    case (busAddr)
      OFS_CTRL:     rdMux = ctrlView;
      OFS_PRESC_LO: rdMux = prescaleLower_ff;
      OFS_PRESC_HI: rdMux = {12'h000, prescaleUpper_ff};
      OFS_DIV_LO:   rdMux = divCount[DIV_LO_W-1:0];
      OFS_DIV_HI:   rdMux = {12'h000, divCount[DIV_W-1:DIV_LO_W]};
      OFS_TIME_LO:  rdMux = timeCount_ff[DIV_LO_W-1:0];
      OFS_TIME_HI:  rdMux = timeCount_ff[TIME_W-1:DIV_LO_W];
      OFS_ALARM_LO: rdMux = alarmValue_ff[DIV_LO_W-1:0];
      OFS_ALARM_HI: rdMux = alarmValue_ff[TIME_W-1:DIV_LO_W];
      default:      rdMux = '0;
    endcase
  end

  // Read data is registered and held until the next read, so the two
  // halves of a running counter are sampled one read apart; software
  // that needs a coherent value stops the clock first.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_ff <= '0;
    end else if (rdHit) begin
      rdData_ff <= rdMux;
    end
  end

  // Outputs straight from flops.
  assign busRdData       = rdData_ff;
  assign tickIrqRequest  = irqLine_ff[0];
  assign alarmIrqRequest = irqLine_ff[1];
  assign wakeReq         = wakeReq_ff;
  assign oscOff          = oscOff_ff;

endmodule : rpac_rtc

// [dv/rpac_rtc_sva.sv]
// Checker for the real-time clock: control read-back, request lines, wake and
// oscillator control. Assumes switch-off and the enables change only by bus writes.
`timescale 1ns/1ps
module rpac_rtc_checker (
  // Clock and reset.
  input wire logic                        clk,
  input wire logic                        rst_b,
  // Bus and power inputs.
  input wire logic                        busSel,
  input wire logic                        busWr,
  input wire logic                        busRd,
  input wire logic [rpac_pkg::ADDR_W-1:0] busAddr,
  input wire logic [rpac_pkg::DATA_W-1:0] busWrData,
  input wire logic [rpac_pkg::DATA_W-1:0] busRdData,
  input wire logic                        powerDown,
  input wire logic                        powerdownWakeConfig,
  // Outputs under watch.
  input wire logic                        tickIrqRequest,
  input wire logic                        alarmIrqRequest,
  input wire logic                        wakeReq,
  input wire logic                        oscOff
);
  import rpac_pkg::*;
  logic       wrCtrl;
  logic       rdCtrl;
  logic       wakeCause;
  logic [2:0] shadow_ff;

  // Control accesses on the bus, and the condition that should wake the chip.
  assign wrCtrl = busSel && busWr && (busAddr == OFS_CTRL);
  assign rdCtrl = busSel && busRd && (busAddr == OFS_CTRL);
  assign wakeCause = powerDown && powerdownWakeConfig && (tickIrqRequest || alarmIrqRequest);

  // Software alone writes switch-off and enables, so this shadow is exact.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shadow_ff <= 3'h0;
    end else if (wrCtrl) begin
      shadow_ff <= {busWrData[CTRL_OFF], busWrData[CTRL_ALARM_EN], busWrData[CTRL_TICK_EN]};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_tickOff; (!shadow_ff[0]) [*3]; endsequence
  sequence s_alarmOff; (!shadow_ff[1]) [*3]; endsequence
  sequence s_clrSeen; $past(wrCtrl) || $past(wrCtrl, 2) || $past(wrCtrl, 3); endsequence

  property p_ctrlRead;
    rdCtrl |=> busRdData[15:5] == 11'h000 &&
      {busRdData[4], busRdData[3], busRdData[1]} == $past(shadow_ff);
  endproperty
  property p_tickQuiet; s_tickOff |-> !tickIrqRequest; endproperty
  property p_alarmQuiet; s_alarmOff |-> !alarmIrqRequest; endproperty
  property p_tickRise; $rose(tickIrqRequest) |-> shadow_ff[0] || $past(shadow_ff[0]); endproperty
  property p_tickFall; $fell(tickIrqRequest) |-> s_clrSeen; endproperty
  property p_alarmFall; $fell(alarmIrqRequest) |-> s_clrSeen; endproperty
  property p_wake; wakeCause |=> wakeReq; endproperty
  property p_wakeCause; wakeReq |-> $past(wakeCause); endproperty
  property p_oscOn; !powerDown |=> !oscOff; endproperty
  property p_oscOff; powerDown && shadow_ff[2] |=> oscOff; endproperty

  a_ctrlRead: assert property (p_ctrlRead) else $error("control read-back wrong");
  a_tickQuiet: assert property (p_tickQuiet) else $error("disabled tick raised");
  a_alarmQuiet: assert property (p_alarmQuiet) else $error("disabled alarm raised");
  a_tickRise: assert property (p_tickRise) else $error("tick rose unenabled");
  a_tickFall: assert property (p_tickFall) else $error("tick fell unasked");
  a_alarmFall: assert property (p_alarmFall) else $error("alarm fell unasked");
  a_wake: assert property (p_wake) else $error("wake missing");
  a_wakeCause: assert property (p_wakeCause) else $error("wake without cause");
  a_oscOn: assert property (p_oscOn) else $error("oscillator off while awake");
  a_oscOff: assert property (p_oscOff) else $error("oscillator left on");
endmodule : rpac_rtc_checker

bind rpac_rtc rpac_rtc_checker i_chk (.clk(clk), .rst_b(rst_b), .busSel(busSel),
  .busWr(busWr), .busRd(busRd), .busAddr(busAddr), .busWrData(busWrData),
  .busRdData(busRdData), .powerDown(powerDown), .powerdownWakeConfig(powerdownWakeConfig),
  .tickIrqRequest(tickIrqRequest), .alarmIrqRequest(alarmIrqRequest), .wakeReq(wakeReq),
  .oscOff(oscOff));

// [dv/rpac_host_model.sv]
// Processor-side model of the internal peripheral bus: whole-word accesses.
// Assumes one access at a time, launched just after a rising clock edge.
`timescale 1ns/1ps
module rpac_host_model (
  // Clock.
  input  wire logic                        clk,
  // Bus master signals.
  output logic                             busSel,
  output logic                             busWr,
  output logic                             busRd,
  output logic      [rpac_pkg::ADDR_W-1:0] busAddr,
  output logic      [rpac_pkg::DATA_W-1:0] busWrData,
  input  wire logic [rpac_pkg::DATA_W-1:0] busRdData
);
  // Idle bus at time zero.
  initial begin
    busSel = 1'b0;
    busWr = 1'b0;
    busRd = 1'b0;
    busAddr = 16'h0000;
    busWrData = 16'h0000;
  end

  // Released address and data lines are inverted and the strobes dropped, so a stale value can never look valid.
  task automatic relBus();
    busSel <= 1'b0;
    busWr <= 1'b0;
    busRd <= 1'b0;
    busAddr <= ~busAddr;
    busWrData <= ~busWrData;
  endtask : relBus

  // Word write, never a bit access on control.
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    busSel <= 1'b1;
    busWr <= 1'b1;
    busAddr <= a;
    busWrData <= d;
    @(posedge clk);
    relBus();
  endtask : wr

  // Word read; the data is registered, so it is taken one edge after the request.
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    busSel <= 1'b1;
    busRd <= 1'b1;
    busAddr <= a;
    @(posedge clk);
    relBus();
    @(posedge clk);
    d = busRdData;
  endtask : rd
endmodule : rpac_host_model

// [dv/tb.sv]
// Self-checking bench for the real-time clock, driven through the bus model.
// Assumes a 10 MHz clock and a prescale of one so a tick takes 64 clocks.
`timescale 1ns/1ps
module tb;
  import rpac_pkg::*;
  localparam int PRESC = 1;
  logic        clk, rst_b, powerDown, powerdownWakeConfig;
  logic        busSel, busWr, busRd, tickIrqRequest, alarmIrqRequest, wakeReq, oscOff;
  logic [15:0] busAddr, busWrData, busRdData;
  int          errorCnt = 0;
  int          checkCount = 0;
  int          cyc = 0;
  int          t1;

  rpac_host_model i_host (.clk(clk), .busSel(busSel), .busWr(busWr), .busRd(busRd),
    .busAddr(busAddr), .busWrData(busWrData), .busRdData(busRdData));
  rpac_rtc i_dut (.clk(clk), .rst_b(rst_b), .busSel(busSel), .busWr(busWr),
    .busRd(busRd), .busAddr(busAddr), .busWrData(busWrData), .busRdData(busRdData),
    .powerDown(powerDown), .powerdownWakeConfig(powerdownWakeConfig),
    .tickIrqRequest(tickIrqRequest), .alarmIrqRequest(alarmIrqRequest),
    .wakeReq(wakeReq), .oscOff(oscOff));

  // Clock and a cycle count used to time the tick period.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errorCnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rdChk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_host.rd(a, d);
    chk(d, exp);
  endtask : rdChk

  // Bounded wait for the tick line to reach a level.
  task automatic waitTick(input logic lvl);
    repeat (300) if (tickIrqRequest !== lvl) @(posedge clk);
    chk(tickIrqRequest, lvl);
  endtask : waitTick

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // Watchdog: the tests need under 2000 clocks.
  initial begin
    repeat (5000) @(posedge clk);
    errorCnt++;
    conclude();
  end

  initial begin
    rst_b = 1'b0;
    powerDown = 1'b0;
    powerdownWakeConfig = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    // Reset value, an unmapped hole and a guarded write while running.
    rdChk(OFS_CTRL, 16'h0000);
    rdChk(16'hec02, 16'h0000);
    i_host.wr(OFS_PRESC_HI, 16'h0005);
    rdChk(OFS_PRESC_HI, 16'h0000);
    $display("test guard done");
    // Stop, load a count two ticks before wrap and an alarm one tick after it.
    i_host.wr(OFS_CTRL, 16'h0010);
    i_host.wr(OFS_PRESC_LO, 16'(PRESC));
    i_host.wr(OFS_PRESC_HI, 16'hfff0);
    rdChk(OFS_PRESC_HI, 16'h0000);
    rdChk(OFS_DIV_LO, 16'h0001);
    rdChk(OFS_DIV_HI, 16'h0000);
    i_host.wr(OFS_TIME_LO, 16'hfffe);
    i_host.wr(OFS_TIME_HI, 16'hffff);
    i_host.wr(OFS_ALARM_LO, 16'h0001);
    i_host.wr(OFS_ALARM_HI, 16'h0000);
    rdChk(OFS_TIME_LO, 16'hfffe);
    rdChk(OFS_TIME_HI, 16'hffff);
    $display("test load done");
    // Run with both sources on; time the gap between two ticks.
    i_host.wr(OFS_CTRL, 16'h000a);
    waitTick(1'b1);
    t1 = cyc;
    i_host.wr(OFS_CTRL, 16'h000a);
    waitTick(1'b0);
    waitTick(1'b1);
    chk(cyc - t1, PRE_DIV * PRESC);
    i_host.wr(OFS_CTRL, 16'h000a);
    repeat (300) if (alarmIrqRequest !== 1'b1) @(posedge clk);
    chk(alarmIrqRequest, 1'b1);
    rdChk(OFS_CTRL, 16'h000f);
    i_host.wr(OFS_CTRL, 16'h001a);
    rdChk(OFS_TIME_LO, 16'h0001);
    rdChk(OFS_TIME_HI, 16'h0000);
    repeat (3 * PRE_DIV) @(posedge clk);
    rdChk(OFS_TIME_LO, 16'h0001);
    rdChk(OFS_CTRL, 16'h001a);
    $display("test count done");
    // Running with both sources disabled must stay silent.
    i_host.wr(OFS_CTRL, 16'h0000);
    repeat (3 * PRE_DIV) @(posedge clk);
    chk(tickIrqRequest, 1'b0);
    rdChk(OFS_CTRL, 16'h0000);
    $display("test quiet done");
    // Power-down: a tick wakes the chip, then switch-off stops the oscillator.
    powerDown <= 1'b1;
    powerdownWakeConfig <= 1'b1;
    i_host.wr(OFS_CTRL, 16'h0002);
    repeat (300) if (wakeReq !== 1'b1) @(posedge clk);
    chk(wakeReq, 1'b1);
    chk(oscOff, 1'b0);
    i_host.wr(OFS_CTRL, 16'h0010);
    repeat (3) @(posedge clk);
    chk(oscOff, 1'b1);
    chk(wakeReq, 1'b0);
    powerDown <= 1'b0;
    repeat (2) @(posedge clk);
    chk(oscOff, 1'b0);
    $display("test power done");
    conclude();
  end
endmodule : tb
